//--- design/sbcs_pkg.sv
package sbcs_pkg;

  // ----------------------------------------
  // instruction classes handled by the sequencer
  // ----------------------------------------
  typedef enum logic [3:0] {
    SBCS_OP_SOFTWARE_BREAK = 4'h0,
    SBCS_OP_AUX_UNIT_TRAP = 4'h1,
    SBCS_OP_INTERRUPT_RETURN = 4'h2,
    SBCS_OP_SHORT_RETURN = 4'h3,
    SBCS_OP_LONG_RETURN = 4'h4,
    SBCS_OP_PUSH_REGISTER = 4'h5,
    SBCS_OP_PULL_REGISTER = 4'h6,
    SBCS_OP_PUSH_INDIRECT_POINTER = 4'h7,
    SBCS_OP_PUSH_ABSOLUTE_WORD = 4'h8,
    SBCS_OP_PUSH_RELATIVE_WORD = 4'h9,
    SBCS_OP_STACK_RELATIVE = 4'ha,
    SBCS_OP_STACK_REL_IND_Y = 4'hb
  } sbcs_op_t;

  // ----------------------------------------
  // one-hot bus cycle kinds
  // ----------------------------------------
  typedef enum logic [9:0] {
    SBCS_ST_IDLE = 10'h001,
    SBCS_ST_FETCH = 10'h002,
    SBCS_ST_OPERAND = 10'h004,
    SBCS_ST_INTERNAL = 10'h008,
    SBCS_ST_STACK_WRITE = 10'h010,
    SBCS_ST_STACK_READ = 10'h020,
    SBCS_ST_POINTER_READ = 10'h040,
    SBCS_ST_DATA = 10'h080,
    SBCS_ST_VECTOR = 10'h100,
    SBCS_ST_NEW_FETCH = 10'h200
  } sbcs_state_t;

  // ----------------------------------------
  // operand widths and counts
  // ----------------------------------------
  localparam logic [1:0] SBCS_WIDTH_8 = 2'h0;
  localparam logic [1:0] SBCS_WIDTH_16 = 2'h1;
  localparam logic [1:0] SBCS_WIDTH_32 = 2'h2;
  localparam logic [2:0] SBCS_LAST_IDX_8 = 3'h0;
  localparam logic [2:0] SBCS_LAST_IDX_16 = 3'h1;
  localparam logic [2:0] SBCS_LAST_IDX_32 = 3'h3;
  // stack writes of a software interrupt: bank (not in emulation mode), pc high, pc low, status
  localparam logic [2:0] SBCS_INT_PUSH_LAST = 3'h3;
  localparam logic [2:0] SBCS_INT_PULL_LAST = 3'h3;
  localparam logic [2:0] SBCS_INT_PULL_LAST_EMU = 3'h2;
  localparam logic [2:0] SBCS_LONG_PULL_LAST = 3'h2;
  localparam logic [2:0] SBCS_WORD_LAST = 3'h1;
  localparam logic [15:0] SBCS_BREAK_LENGTH = 16'h0002;
  localparam logic [15:0] SBCS_RELATIVE_LENGTH = 16'h0003;
  localparam logic [7:0] SBCS_BANK_ZERO = 8'h00;
  localparam logic [23:0] SBCS_IDLE_ADDRESS = 24'h000000;

endpackage

//--- design/sbcs_sequencer.sv
`timescale 1ns/1ns
module sbcs_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input sbcs_pkg::sbcs_op_t start_op,
  input wire logic [1:0] start_width,
  input wire logic start_write,
  input wire logic emulation_mode,
  input wire logic [15:0] program_counter,
  input wire logic [7:0] program_bank_register,
  input wire logic [7:0] data_bank_register,
  input wire logic [15:0] stack_pointer,
  input wire logic [15:0] direct_register,
  input wire logic [15:0] index_y,
  input wire logic [7:0] status_byte,
  input wire logic [31:0] register_value,
  input wire logic [15:0] vector_location,
  input wire logic [7:0] data_in,
  output logic ready,
  output logic last_cycle,
  output logic [23:0] address,
  output logic [7:0] data_out,
  output logic read_write_n,
  output logic vector_pull_n,
  output logic memory_lock_n,
  output logic valid_data_strobe,
  output logic valid_program_strobe,
  output logic [31:0] pulled_value,
  output logic [15:0] operand_word,
  output logic [15:0] pointer_word,
  output logic [15:0] final_stack_pointer
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  sbcs_pkg::sbcs_state_t state_reg, state_next;
  sbcs_pkg::sbcs_op_t op_reg;
  logic [1:0] width_reg;
  logic write_reg, emu_reg, late_reg, late_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [15:0] sp_reg, off_reg, ptr_reg;
  logic [31:0] pull_reg;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire is_int = op_reg == sbcs_pkg::SBCS_OP_SOFTWARE_BREAK ||
    op_reg == sbcs_pkg::SBCS_OP_AUX_UNIT_TRAP;
  wire is_rti = op_reg == sbcs_pkg::SBCS_OP_INTERRUPT_RETURN;
  wire is_rts = op_reg == sbcs_pkg::SBCS_OP_SHORT_RETURN;
  wire is_rtl = op_reg == sbcs_pkg::SBCS_OP_LONG_RETURN;
  wire is_push = op_reg == sbcs_pkg::SBCS_OP_PUSH_REGISTER;
  wire is_pull = op_reg == sbcs_pkg::SBCS_OP_PULL_REGISTER;
  wire is_pei = op_reg == sbcs_pkg::SBCS_OP_PUSH_INDIRECT_POINTER;
  wire is_pea = op_reg == sbcs_pkg::SBCS_OP_PUSH_ABSOLUTE_WORD;
  wire is_per = op_reg == sbcs_pkg::SBCS_OP_PUSH_RELATIVE_WORD;
  wire is_sr = op_reg == sbcs_pkg::SBCS_OP_STACK_RELATIVE;
  wire is_sriy = op_reg == sbcs_pkg::SBCS_OP_STACK_REL_IND_Y;
  wire [2:0] last_idx = width_reg == sbcs_pkg::SBCS_WIDTH_32 ? sbcs_pkg::SBCS_LAST_IDX_32 :
    width_reg == sbcs_pkg::SBCS_WIDTH_16 ? sbcs_pkg::SBCS_LAST_IDX_16 :
    sbcs_pkg::SBCS_LAST_IDX_8;
  wire [2:0] rti_last = emu_reg ? sbcs_pkg::SBCS_INT_PULL_LAST_EMU :
    sbcs_pkg::SBCS_INT_PULL_LAST;
  wire cnt_word_end = cnt_reg == sbcs_pkg::SBCS_WORD_LAST;

  // ----------------------------------------
  // address arithmetic
  // ----------------------------------------
  wire [15:0] pc_plus_one = program_counter + 16'h0001;
  wire [15:0] return_pc = program_counter + sbcs_pkg::SBCS_BREAK_LENGTH;
  wire [15:0] relative_sum = program_counter + sbcs_pkg::SBCS_RELATIVE_LENGTH + off_reg;
  wire [15:0] stack_rel = stack_pointer + {8'h00, off_reg[7:0]} + {13'h0000, cnt_reg};
  wire [15:0] direct_rel = direct_register + {8'h00, off_reg[7:0]} + {13'h0000, cnt_reg};
  wire [23:0] indexed = {data_bank_register, ptr_reg} + {8'h00, index_y} +
    {21'h000000, cnt_reg};
  wire [15:0] stack_read_addr = sp_reg + 16'h0001;
  wire [15:0] pulled_pc = is_rti ? pull_reg[23:8] : pull_reg[15:0];
  wire [7:0] pulled_bank = is_rti ? (emu_reg ? program_bank_register : pull_reg[31:24]) :
    is_rtl ? pull_reg[23:16] : program_bank_register;
  wire [2:0] push_idx = last_idx - cnt_reg;
  wire [4:0] push_bit = {push_idx[1:0], 3'h0};
  wire [4:0] data_bit = {cnt_reg[1:0], 3'h0};
  wire [15:0] push_word = is_pei ? ptr_reg : is_per ? relative_sum : off_reg;
  wire [7:0] int_byte = cnt_reg == 3'h0 ? program_bank_register :
    cnt_reg == 3'h1 ? return_pc[15:8] : cnt_reg == 3'h2 ? return_pc[7:0] : status_byte;

  // ----------------------------------------
  // bus cycle outputs
  // ----------------------------------------
  wire in_fetch = state_reg == sbcs_pkg::SBCS_ST_FETCH || state_reg == sbcs_pkg::SBCS_ST_NEW_FETCH;
  wire in_data_cycle = state_reg == sbcs_pkg::SBCS_ST_STACK_WRITE ||
    state_reg == sbcs_pkg::SBCS_ST_STACK_READ || state_reg == sbcs_pkg::SBCS_ST_POINTER_READ ||
    state_reg == sbcs_pkg::SBCS_ST_DATA || state_reg == sbcs_pkg::SBCS_ST_VECTOR;
  assign valid_data_strobe = in_fetch || in_data_cycle;
  assign valid_program_strobe = in_fetch || state_reg == sbcs_pkg::SBCS_ST_OPERAND;
  assign vector_pull_n = state_reg != sbcs_pkg::SBCS_ST_VECTOR;
  assign memory_lock_n = 1'b1;
  assign read_write_n = !(state_reg == sbcs_pkg::SBCS_ST_STACK_WRITE ||
    (state_reg == sbcs_pkg::SBCS_ST_DATA && write_reg));
  assign ready = state_reg == sbcs_pkg::SBCS_ST_IDLE;
  assign pulled_value = pull_reg;
  assign operand_word = off_reg;
  assign pointer_word = ptr_reg;
  assign final_stack_pointer = sp_reg;

  always_comb begin
    address = sbcs_pkg::SBCS_IDLE_ADDRESS;
    data_out = 8'h00;
    unique case (state_reg)
      sbcs_pkg::SBCS_ST_IDLE: address = sbcs_pkg::SBCS_IDLE_ADDRESS;
      sbcs_pkg::SBCS_ST_FETCH: address = {program_bank_register, program_counter};
      sbcs_pkg::SBCS_ST_OPERAND: address = {program_bank_register,
        pc_plus_one + {13'h0000, cnt_reg}};
      sbcs_pkg::SBCS_ST_INTERNAL: begin
        if (late_reg && is_rts) begin
          address = {program_bank_register, pull_reg[15:0] - 16'h0001};
        end else if (late_reg) begin
          address = {sbcs_pkg::SBCS_BANK_ZERO, stack_rel + 16'h0001};
        end else if (is_per) begin
          address = {program_bank_register, pc_plus_one + 16'h0001};
        end else begin
          address = {program_bank_register, pc_plus_one};
        end
      end
      sbcs_pkg::SBCS_ST_STACK_WRITE: begin
        address = {sbcs_pkg::SBCS_BANK_ZERO, sp_reg};
        if (is_int) begin
          data_out = int_byte;
        end else if (is_push) begin
          data_out = register_value[push_bit +: 8];
        end else begin
          data_out = cnt_reg == 3'h0 ? push_word[15:8] : push_word[7:0];
        end
      end
      sbcs_pkg::SBCS_ST_STACK_READ: address = {sbcs_pkg::SBCS_BANK_ZERO, stack_read_addr};
      sbcs_pkg::SBCS_ST_POINTER_READ: address = {sbcs_pkg::SBCS_BANK_ZERO,
        is_pei ? direct_rel : stack_rel};
      sbcs_pkg::SBCS_ST_DATA: begin
        address = is_sr ? {sbcs_pkg::SBCS_BANK_ZERO, stack_rel} : indexed;
        data_out = register_value[data_bit +: 8];
      end
      sbcs_pkg::SBCS_ST_VECTOR: address = {sbcs_pkg::SBCS_BANK_ZERO,
        vector_location + {13'h0000, cnt_reg}};
      sbcs_pkg::SBCS_ST_NEW_FETCH: begin
        if (is_int) begin
          address = {sbcs_pkg::SBCS_BANK_ZERO, ptr_reg};
        end else if (is_rti) begin
          address = {pulled_bank, pulled_pc};
        end else begin
          address = {pulled_bank, pulled_pc + 16'h0001};
        end
      end
    endcase
  end

  // ----------------------------------------
  // cycle sequencing
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + 3'h1;
    late_next = late_reg;
    last_cycle = 1'b0;
    unique case (state_reg)
      sbcs_pkg::SBCS_ST_IDLE: begin
        cnt_next = 3'h0;
        late_next = 1'b0;
        if (start) begin
          state_next = sbcs_pkg::SBCS_ST_FETCH;
        end
      end
      sbcs_pkg::SBCS_ST_FETCH: begin
        cnt_next = 3'h0;
        if (is_rti || is_rts || is_rtl || is_pull || is_push) begin
          state_next = sbcs_pkg::SBCS_ST_INTERNAL;
        end else begin
          state_next = sbcs_pkg::SBCS_ST_OPERAND;
        end
      end
      sbcs_pkg::SBCS_ST_OPERAND: begin
        if ((is_pea || is_per) && cnt_reg == 3'h0) begin
          state_next = sbcs_pkg::SBCS_ST_OPERAND;
        end else if (is_int) begin
          state_next = sbcs_pkg::SBCS_ST_STACK_WRITE;
          cnt_next = emu_reg ? 3'h1 : 3'h0;
        end else if (is_pea) begin
          state_next = sbcs_pkg::SBCS_ST_STACK_WRITE;
          cnt_next = 3'h0;
        end else if (is_pei && direct_register[7:0] == 8'h00) begin
          state_next = sbcs_pkg::SBCS_ST_POINTER_READ;
          cnt_next = 3'h0;
        end else begin
          state_next = sbcs_pkg::SBCS_ST_INTERNAL;
          cnt_next = 3'h0;
        end
      end
      sbcs_pkg::SBCS_ST_INTERNAL: begin
        if ((is_rti || is_rts || is_rtl || is_pull) && !late_reg && cnt_reg == 3'h0) begin
          state_next = sbcs_pkg::SBCS_ST_INTERNAL;
        end else if (late_reg && is_rts) begin
          state_next = sbcs_pkg::SBCS_ST_NEW_FETCH;
        end else begin
          cnt_next = 3'h0;
          if (is_rti || is_rts || is_rtl || is_pull) begin
            state_next = sbcs_pkg::SBCS_ST_STACK_READ;
          end else if (is_push || is_per) begin
            state_next = sbcs_pkg::SBCS_ST_STACK_WRITE;
          end else if (is_pei || (is_sriy && !late_reg)) begin
            state_next = sbcs_pkg::SBCS_ST_POINTER_READ;
          end else begin
            state_next = sbcs_pkg::SBCS_ST_DATA;
          end
        end
      end
      sbcs_pkg::SBCS_ST_STACK_WRITE: begin
        if (is_int && cnt_reg == sbcs_pkg::SBCS_INT_PUSH_LAST) begin
          state_next = sbcs_pkg::SBCS_ST_VECTOR;
          cnt_next = 3'h0;
        end else if ((is_push && cnt_reg == last_idx) || (!is_int && !is_push && cnt_word_end)) begin
          state_next = sbcs_pkg::SBCS_ST_IDLE;
          last_cycle = 1'b1;
        end
      end
      sbcs_pkg::SBCS_ST_STACK_READ: begin
        if ((is_rti && cnt_reg == rti_last) || (is_rtl && cnt_reg == sbcs_pkg::SBCS_LONG_PULL_LAST)) begin
          state_next = sbcs_pkg::SBCS_ST_NEW_FETCH;
        end else if (is_rts && cnt_word_end) begin
          state_next = sbcs_pkg::SBCS_ST_INTERNAL;
          late_next = 1'b1;
        end else if (is_pull && cnt_reg == last_idx) begin
          state_next = sbcs_pkg::SBCS_ST_IDLE;
          last_cycle = 1'b1;
        end
      end
      sbcs_pkg::SBCS_ST_POINTER_READ: begin
        if (cnt_word_end) begin
          cnt_next = 3'h0;
          state_next = is_pei ? sbcs_pkg::SBCS_ST_STACK_WRITE : sbcs_pkg::SBCS_ST_INTERNAL;
          late_next = 1'b1;
        end
      end
      sbcs_pkg::SBCS_ST_DATA: begin
        if (cnt_reg == last_idx) begin
          state_next = sbcs_pkg::SBCS_ST_IDLE;
          last_cycle = 1'b1;
        end
      end
      sbcs_pkg::SBCS_ST_VECTOR: begin
        if (cnt_word_end) begin
          state_next = sbcs_pkg::SBCS_ST_NEW_FETCH;
        end
      end
      sbcs_pkg::SBCS_ST_NEW_FETCH: begin
        state_next = sbcs_pkg::SBCS_ST_IDLE;
        last_cycle = 1'b1;
      end
      default: begin
        state_next = sbcs_pkg::SBCS_ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // the core keeps the register inputs steady from start to last_cycle; only
  // the stack pointer walks here, so pushes and pulls need no adder per byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= sbcs_pkg::SBCS_ST_IDLE;
      cnt_reg <= 3'h0;
      late_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      late_reg <= late_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_reg <= sbcs_pkg::SBCS_OP_SOFTWARE_BREAK;
      width_reg <= sbcs_pkg::SBCS_WIDTH_8;
      write_reg <= 1'b0;
      emu_reg <= 1'b0;
      sp_reg <= 16'h0000;
    end else if (ready && start) begin
      op_reg <= start_op;
      width_reg <= start_width;
      write_reg <= start_write;
      emu_reg <= emulation_mode;
      sp_reg <= stack_pointer;
    end else if (state_reg == sbcs_pkg::SBCS_ST_STACK_WRITE) begin
      sp_reg <= sp_reg - 16'h0001;
    end else if (state_reg == sbcs_pkg::SBCS_ST_STACK_READ) begin
      sp_reg <= stack_read_addr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      off_reg <= 16'h0000;
      ptr_reg <= 16'h0000;
      pull_reg <= 32'h00000000;
    end else if (state_reg == sbcs_pkg::SBCS_ST_OPERAND) begin
      off_reg[data_bit[3:0] +: 8] <= data_in;
    end else if (state_reg == sbcs_pkg::SBCS_ST_POINTER_READ ||
        state_reg == sbcs_pkg::SBCS_ST_VECTOR) begin
      ptr_reg[data_bit[3:0] +: 8] <= data_in;
    end else if (state_reg == sbcs_pkg::SBCS_ST_STACK_READ ||
        (state_reg == sbcs_pkg::SBCS_ST_DATA && !write_reg)) begin
      pull_reg[data_bit +: 8] <= data_in;
    end
  end

endmodule

//--- dv/sbcs_monitor.sv
`timescale 1ns/1ns
// ----------------------------------------
// bus cycle checker
// ----------------------------------------
module sbcs_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input sbcs_pkg::sbcs_op_t start_op,
  input wire logic [15:0] program_counter,
  input wire logic [7:0] program_bank_register,
  input wire logic ready,
  input wire logic last_cycle,
  input wire logic [23:0] address,
  input wire logic read_write_n,
  input wire logic vector_pull_n,
  input wire logic memory_lock_n,
  input wire logic valid_data_strobe,
  input wire logic valid_program_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sbcs_pkg::sbcs_op_t op_reg;
  wire logic dat = valid_data_strobe && !valid_program_strobe;
  // the ports show the class only at start, so keep it for the whole sequence
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_reg <= sbcs_pkg::SBCS_OP_SHORT_RETURN;
    end else if (ready && start) begin
      op_reg <= start_op;
    end
  end
  wire logic pull_cls = op_reg inside {sbcs_pkg::SBCS_OP_INTERRUPT_RETURN,
    sbcs_pkg::SBCS_OP_SHORT_RETURN, sbcs_pkg::SBCS_OP_LONG_RETURN,
    sbcs_pkg::SBCS_OP_PULL_REGISTER};
  // stack relative writes ascend, every other write descends
  wire logic push_cls = !(op_reg inside {sbcs_pkg::SBCS_OP_STACK_RELATIVE,
    sbcs_pkg::SBCS_OP_STACK_REL_IND_Y});

  property p_lock_high; memory_lock_n; endproperty
  a_lock_high: assert property (p_lock_high) else $error("lock went low");
  property p_idle_quiet; ready |-> !valid_data_strobe && !valid_program_strobe
    && vector_pull_n && read_write_n && address == 24'h000000; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle bus busy");
  property p_first_fetch; ready && start |=> valid_data_strobe && valid_program_strobe
    && address == {$past(program_bank_register), $past(program_counter)}; endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("bad opcode fetch");
  property p_signature; ready && start && start_op inside {sbcs_pkg::SBCS_OP_SOFTWARE_BREAK,
    sbcs_pkg::SBCS_OP_AUX_UNIT_TRAP} |=> ##1 dat == 1'b0 && valid_program_strobe
    && address == {$past(program_bank_register, 2), $past(program_counter, 2) + 16'h1};
  endproperty
  a_signature: assert property (p_signature) else $error("bad signature read");
  property p_vector_pair; $fell(vector_pull_n) |-> dat && read_write_n ##1 !vector_pull_n
    && dat && address == $past(address) + 24'h1 ##1 vector_pull_n && valid_data_strobe
    && valid_program_strobe; endproperty
  a_vector_pair: assert property (p_vector_pair) else $error("bad vector reads");
  property p_write_kind; !read_write_n |-> dat && vector_pull_n; endproperty
  a_write_kind: assert property (p_write_kind) else $error("bad write strobes");
  property p_push_desc; !read_write_n && !$past(read_write_n) && push_cls
    |-> address == $past(address) - 24'h1; endproperty
  a_push_desc: assert property (p_push_desc) else $error("push not descending");
  property p_pull_asc; pull_cls && dat && read_write_n && $past(valid_data_strobe)
    && !$past(valid_program_strobe) |-> address == $past(address) + 24'h1; endproperty
  a_pull_asc: assert property (p_pull_asc) else $error("pull not ascending");
  property p_internal; !valid_data_strobe && !valid_program_strobe
    |-> read_write_n && vector_pull_n; endproperty
  a_internal: assert property (p_internal) else $error("internal cycle active");
  property p_end_ready; last_cycle |=> ready; endproperty
  a_end_ready: assert property (p_end_ready) else $error("no idle after end");

  c_vector: cover property ($fell(vector_pull_n));
  c_write_run: cover property (!read_write_n [*4]);
  c_pull: cover property (pull_cls && dat ##1 dat);
endmodule

//--- dv/sbcs_memory_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// memory on the processor bus
// ----------------------------------------
module sbcs_memory_model (
  input wire logic clk,
  input wire logic [23:0] address,
  input wire logic read_write_n,
  input wire logic valid_data_strobe,
  input wire logic valid_program_strobe,
  output logic [7:0] data_in
);
  logic [7:0] last_reg;
  wire logic rd = read_write_n && (valid_data_strobe || valid_program_strobe);
  // unselected cycles toggle the bus so a stale byte never passes for data
  assign data_in = rd ? (address[7:0] ^ address[15:8] ^ address[23:16] ^ 8'h3c) : ~last_reg;
  always_ff @(posedge clk) begin
    last_reg <= data_in;
  end
endmodule

//--- dv/tb_stack_bus_cycle_sequencer.sv
`timescale 1ns/1ns
// ----------------------------------------
// stack sequencer bench
// ----------------------------------------
module tb_stack_bus_cycle_sequencer;
  localparam logic [3:0] FETCH = 4'hf;
  localparam logic [3:0] OPND = 4'hb;
  localparam logic [3:0] INTL = 4'h9;
  localparam logic [3:0] RD = 4'hd;
  localparam logic [3:0] WR = 4'hc;
  localparam logic [3:0] VEC = 4'h5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  sbcs_pkg::sbcs_op_t start_op = sbcs_pkg::SBCS_OP_SOFTWARE_BREAK;
  logic [1:0] start_width = 2'h0;
  logic start_write = 1'b0;
  logic emulation_mode = 1'b0;
  logic [15:0] program_counter = 16'h1234;
  logic [7:0] program_bank_register = 8'h5b;
  logic [7:0] data_bank_register = 8'h7e;
  logic [15:0] stack_pointer = 16'h01f0;
  logic [15:0] direct_register = 16'h0300;
  logic [15:0] index_y = 16'h00f0;
  logic [7:0] status_byte = 8'ha5;
  logic [31:0] register_value = 32'h89abcdef;
  logic [15:0] vector_location = 16'hfffe;
  logic [7:0] data_in;
  logic ready, last_cycle, read_write_n, vector_pull_n, memory_lock_n;
  logic valid_data_strobe, valid_program_strobe;
  logic [23:0] address;
  logic [7:0] data_out;
  logic [31:0] pulled_value;
  logic [15:0] operand_word, pointer_word, final_stack_pointer;
  logic [31:0] pv;
  logic [23:0] adr_q [16];
  logic [3:0] st_q [16];
  logic [7:0] dout_q [16];
  int ncyc;
  int bad_count = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  sbcs_sequencer sbcs_sequencer_inst (.clk, .rst_n, .start, .start_op, .start_width,
    .start_write, .emulation_mode, .program_counter, .program_bank_register,
    .data_bank_register, .stack_pointer, .direct_register, .index_y, .status_byte,
    .register_value, .vector_location, .data_in, .ready, .last_cycle, .address, .data_out,
    .read_write_n, .vector_pull_n, .memory_lock_n, .valid_data_strobe, .valid_program_strobe,
    .pulled_value, .operand_word, .pointer_word, .final_stack_pointer);
  sbcs_memory_model sbcs_memory_model_inst (.clk, .address, .read_write_n,
    .valid_data_strobe, .valid_program_strobe, .data_in);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic logic [7:0] mem(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
  endfunction
  task automatic stop_test();
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int i, input logic [31:0] a, input logic [3:0] s);
    check("address", {8'h00, adr_q[i]}, a);
    check("strobes", {28'h0, st_q[i]}, {28'h0, s});
  endtask
  // records one sequence; an extra idle cycle lets the last read land in pulled_value
  task automatic run(input sbcs_pkg::sbcs_op_t op, input logic [1:0] w, input logic wr,
    input logic emu);
    logic lc;
    start <= 1'b1;
    start_op <= op;
    start_width <= w;
    start_write <= wr;
    emulation_mode <= emu;
    @(posedge clk);
    start <= 1'b0;
    ncyc = 0;
    lc = 1'b0;
    while (!lc && ncyc < 16) begin
      #1;
      adr_q[ncyc] = address;
      st_q[ncyc] = {vector_pull_n, valid_data_strobe, valid_program_strobe, read_write_n};
      dout_q[ncyc] = data_out;
      lc = (last_cycle === 1'b1);
      ncyc++;
      @(posedge clk);
    end
    #1;
    pv = pulled_value;
    @(posedge clk);
    if (!lc) begin
      check("completion", 32'h0, 32'h1);
      stop_test();
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_swi(input sbcs_pkg::sbcs_op_t op, input int k);
    run(op, 2'h0, 1'b0, k[0]);
    check("length", ncyc, 9 - k);
    cyc(1, 32'h5b1235, OPND);
    for (int i = 0; i < 4 - k; i++) cyc(2 + i, 32'h01f0 - i, WR);
    check("first push", dout_q[2], k ? 8'h12 : 8'h5b);
    check("pc high", dout_q[3 - k], 8'h12);
    check("pc low", dout_q[4 - k], 8'h36);
    check("status", dout_q[5 - k], 8'ha5);
    cyc(6 - k, 32'hfffe, VEC);
    cyc(7 - k, 32'hffff, VEC);
    cyc(8 - k, {mem(32'hffff), mem(32'hfffe)}, FETCH);
  endtask
  task automatic t_rti(input int k);
    run(sbcs_pkg::SBCS_OP_INTERRUPT_RETURN, 2'h0, 1'b0, k[0]);
    check("length", ncyc, 8 - k);
    cyc(2, 32'h5b1235, INTL);
    for (int i = 0; i < 4 - k; i++) cyc(3 + i, 32'h01f1 + i, RD);
    check("pulled", pv[23:0], {mem(32'h01f3), mem(32'h01f2), mem(32'h01f1)});
    cyc(7 - k, {k ? 8'h5b : mem(32'h01f4), mem(32'h01f3), mem(32'h01f2)}, FETCH);
  endtask
  task automatic t_returns();
    logic [15:0] nv;
    run(sbcs_pkg::SBCS_OP_SHORT_RETURN, 2'h0, 1'b0, 1'b0);
    nv = {mem(32'h01f2), mem(32'h01f1)};
    check("length", ncyc, 7);
    cyc(4, 32'h01f2, RD);
    cyc(5, {8'h5b, nv - 16'h1}, INTL);
    cyc(6, {8'h5b, nv + 16'h1}, FETCH);
    run(sbcs_pkg::SBCS_OP_LONG_RETURN, 2'h0, 1'b0, 1'b0);
    check("length", ncyc, 7);
    cyc(5, 32'h01f3, RD);
    check("pulled", pv[23:0], {mem(32'h01f3), mem(32'h01f2), mem(32'h01f1)});
  endtask
  task automatic t_stack(input int w);
    int nb;
    nb = 1 << w;
    run(sbcs_pkg::SBCS_OP_PUSH_REGISTER, w[1:0], 1'b0, 1'b0);
    check("length", ncyc, 2 + nb);
    for (int i = 0; i < nb; i++) begin
      cyc(2 + i, 32'h01f0 - i, WR);
      check("push", dout_q[2 + i], register_value[8 * (nb - 1 - i) +: 8]);
    end
    run(sbcs_pkg::SBCS_OP_PULL_REGISTER, w[1:0], 1'b0, 1'b0);
    check("length", ncyc, 3 + nb);
    for (int i = 0; i < nb; i++) begin
      cyc(3 + i, 32'h01f1 + i, RD);
      check("pull", pv[8 * i +: 8], mem(32'h01f1 + i));
    end
  endtask
  task automatic t_sr(input sbcs_pkg::sbcs_op_t op, input int w, input logic wr);
    logic [15:0] b;
    logic [23:0] d;
    int nb;
    int n0;
    nb = 1 << w;
    run(op, w[1:0], wr, 1'b0);
    b = 16'h01f0 + {8'h00, mem(32'h5b1235)};
    n0 = (op == sbcs_pkg::SBCS_OP_STACK_REL_IND_Y) ? 6 : 3;
    d = (n0 == 6) ? {8'h7e, mem(b + 16'h1), mem(b)} + 24'h0000f0 : {8'h00, b};
    check("length", ncyc, n0 + nb);
    cyc(2, 32'h5b1235, INTL);
    if (n0 == 6) cyc(5, {8'h00, b + 16'h1}, INTL);
    for (int i = 0; i < nb; i++) begin
      cyc(n0 + i, d + i, wr ? WR : RD);
      check("data", wr ? dout_q[n0 + i] : pv[8 * i +: 8],
        wr ? register_value[8 * i +: 8] : mem(d + i));
    end
  endtask
  task automatic t_pei(input logic [7:0] dl);
    logic [15:0] b;
    int x;
    direct_register <= {8'h03, dl};
    run(sbcs_pkg::SBCS_OP_PUSH_INDIRECT_POINTER, 2'h0, 1'b0, 1'b0);
    x = (dl != 8'h00) ? 1 : 0;
    b = direct_register + {8'h00, mem(32'h5b1235)};
    check("length", ncyc, 6 + x);
    cyc(1 + x, 32'h5b1235, x ? INTL : OPND);
    cyc(3 + x, {8'h00, b + 16'h1}, RD);
    cyc(4 + x, 32'h01f0, WR);
    check("high", dout_q[4 + x], mem(b + 16'h1));
    check("low", dout_q[5 + x], mem(b));
    check("pointer", pointer_word, {mem(b + 16'h1), mem(b)});
  endtask
  task automatic t_per();
    logic [15:0] v;
    program_counter <= 16'h20c0;
    run(sbcs_pkg::SBCS_OP_PUSH_RELATIVE_WORD, 2'h0, 1'b0, 1'b0);
    v = 16'h20c3 + {mem(32'h5b20c2), mem(32'h5b20c1)};
    check("length", ncyc, 6);
    cyc(3, 32'h5b20c2, INTL);
    check("sum high", dout_q[4], v[15:8]);
    check("sum low", dout_q[5], v[7:0]);
    check("offset", operand_word, {mem(32'h5b20c2), mem(32'h5b20c1)});
    check("final sp", final_stack_pointer, 16'h01ee);
    run(sbcs_pkg::SBCS_OP_PUSH_ABSOLUTE_WORD, 2'h0, 1'b0, 1'b0);
    check("length", ncyc, 5);
    cyc(2, 32'h5b20c2, OPND);
    cyc(3, 32'h01f0, WR);
    cyc(4, 32'h01ef, WR);
    check("abs high", dout_q[3], mem(32'h5b20c2));
    check("abs low", dout_q[4], mem(32'h5b20c1));
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      t_swi(sbcs_pkg::SBCS_OP_SOFTWARE_BREAK, k);
      t_swi(sbcs_pkg::SBCS_OP_AUX_UNIT_TRAP, k);
      t_rti(k);
    end
    t_returns();
    for (int w = 0; w < 3; w++) begin
      t_stack(w);
      t_sr(sbcs_pkg::SBCS_OP_STACK_RELATIVE, w, w[0]);
      t_sr(sbcs_pkg::SBCS_OP_STACK_REL_IND_Y, w, !w[0]);
    end
    t_pei(8'h00);
    t_pei(8'h40);
    t_per();
    stop_test();
  end
endmodule

bind sbcs_sequencer sbcs_monitor sbcs_monitor_inst (.clk, .rst_n, .start, .start_op,
  .program_counter, .program_bank_register, .ready, .last_cycle, .address, .read_write_n,
  .vector_pull_n, .memory_lock_n, .valid_data_strobe, .valid_program_strobe);
